/* logic/tx_ctrl_pkg.sv */
// shared constants and types for the transmit-path control block
package tx_ctrl_pkg;
  // register offsets (byte pointer on the 2-wire interface)
  localparam logic [7:0] RX_CTL_OFS = 8'h04;
  localparam logic [7:0] TX_CTL_OFS = 8'h0A;
  localparam logic [7:0] EQ_OFS = 8'h0B;
  localparam logic [7:0] MOD_OFS = 8'h0C;
  localparam logic [7:0] REC_OFS = 8'h13;
  localparam logic [7:0] BW_OFS = 8'h33;
  localparam logic [7:0] MON_SUP_OFS = 8'h40;
  localparam logic [7:0] MON_BIAS_OFS = 8'h41;
  localparam logic [7:0] MON_PD_OFS = 8'h42;
  localparam logic [7:0] MON_TEMP_OFS = 8'h43;
  localparam logic [7:0] STAT_OFS = 8'h44;
  // reset values
  localparam logic [7:0] RX_CTL_RST = 8'h00;
  localparam logic [7:0] TX_CTL_RST = 8'h00;
  localparam logic [7:0] EQ_RST = 8'h00;
  localparam logic [7:0] MOD_RST = 8'h00;
  localparam logic [7:0] REC_RST = 8'h00;
  localparam logic [7:0] BW_RST = 8'h00;
  // field positions
  localparam int RXC_BYP = 3;
  localparam int TXC_EQ_OFF = 1;
  localparam int TXC_BYP = 3;
  localparam int TXC_REC_OFF = 4;
  localparam int TXC_INV = 5;
  localparam int TXC_DRV_OFF = 6;
  localparam int EQ_LVL_LSB = 0;
  localparam int BW_LSB = 5;
  localparam int REC_DIV_LSB = 0;
  localparam int REC_FL_OFF = 3;
  localparam int REC_FD_OFF = 4;
  localparam int REC_FD_ON = 5;
  localparam int REC_PRE_LSB = 6;
  // serial interface
  localparam logic [6:0] DEV_ADDR_DEF = 7'h50;
  localparam logic [3:0] BYTE_BITS = 4'h8;
  // timing
  localparam int CLK_PERIOD_NS = 40;
  localparam int LOCK_TIME_NS = 2000000;
  localparam int LOCK_CYC = LOCK_TIME_NS / CLK_PERIOD_NS;
  localparam int TMR_W = 16;
  typedef enum {TW_IDLE, TW_ADDR, TW_ADDR_ACK, TW_PTR, TW_PTR_ACK,
    TW_WDATA, TW_WDATA_ACK, TW_RDATA, TW_RDATA_ACK} twi_state_t;
  typedef enum {FD_WAIT, FD_SEARCH, FD_FOUND} fd_state_t;
endpackage

/* logic/pin_evt_if.sv */
// synchronised pin levels and serial-bus events between internal modules
`timescale 1ns/1ps
interface pin_evt_if;
  logic sckRise;
  logic sckFall;
  logic sdaLvl;
  logic startSeen;
  logic stopSeen;
  logic sigPresent;
  logic freqFound;
  modport src (output sckRise, sckFall, sdaLvl, startSeen, stopSeen, sigPresent, freqFound);
  modport dst (input sckRise, sckFall, sdaLvl, startSeen, stopSeen, sigPresent, freqFound);
endinterface

/* logic/pin_sync.sv */
// two-flop synchronisers for external pins and serial-bus edge detection
`timescale 1ns/1ps
module pin_sync (
  input wire logic clock,
  input wire logic nrst,
  input wire logic sck,
  input wire logic sdaIn,
  input wire logic sigDetect,
  input wire logic freqLock,
  pin_evt_if.src evt
);
  logic [3:0] pinVec;
  logic [3:0] meta_ff;
  logic [3:0] sync_ff;
  logic [1:0] hist_ff;

  assign pinVec = {freqLock, sigDetect, sdaIn, sck};

  // two flops per pin
  genvar i;
  generate
    for (i = 0; i < 4; i++)
    begin : g_sync
      always_ff @(posedge clock or negedge nrst)
      begin
        if (!nrst)
        begin
          // bus pins idle high, detector pins idle low: no false event after reset
          meta_ff[i] <= 1'(i < 2);
          sync_ff[i] <= 1'(i < 2);
        end
        else
        begin
          meta_ff[i] <= pinVec[i];
          sync_ff[i] <= meta_ff[i];
        end
      end
    end
  endgenerate

  // previous level of sck and sda for edge finding
  always_ff @(posedge clock or negedge nrst)
  begin
    if (!nrst)
      hist_ff <= 2'h3;
    else
      hist_ff <= sync_ff[1:0];
  end

  // start: sda falls with sck high; stop: sda rises with sck high
  assign evt.sckRise = sync_ff[0] & ~hist_ff[0];
  assign evt.sckFall = ~sync_ff[0] & hist_ff[0];
  assign evt.sdaLvl = sync_ff[1];
  assign evt.startSeen = sync_ff[0] & hist_ff[0] & hist_ff[1] & ~sync_ff[1];
  assign evt.stopSeen = sync_ff[0] & hist_ff[0] & ~hist_ff[1] & sync_ff[1];
  assign evt.sigPresent = sync_ff[2];
  assign evt.freqFound = sync_ff[3];
endmodule

/* logic/freq_det_ctrl.sv */
// frequency detector sequencing: search on signal, power down after lock
`timescale 1ns/1ps
module freq_det_ctrl
  import tx_ctrl_pkg::*;
#(
  parameter int LOCK_CYCLES = LOCK_CYC
) (
  input wire logic clock,
  input wire logic nrst,
  pin_evt_if.dst evt,
  input wire logic forceOn,
  input wire logic forceOff,
  input wire logic recOff,
  output logic detectorOn,
  output logic searchStart,
  output logic locked
);
  fd_state_t st_ff;
  logic [TMR_W-1:0] tmr_ff;
  logic on_ff;
  logic go_ff;

  // state, retry timer, detector power
  always_ff @(posedge clock or negedge nrst)
  begin
    if (!nrst)
    begin
      st_ff <= FD_WAIT;
      tmr_ff <= '0;
      on_ff <= 1'b0;
      go_ff <= 1'b0;
    end
    else
    begin
      go_ff <= 1'b0;
      if (forceOff || recOff)
      begin
        st_ff <= FD_WAIT; // force-off beats force-on
        on_ff <= 1'b0;
      end
      else
      begin
        case (st_ff)
          FD_WAIT:
          begin
            on_ff <= forceOn;
            if (evt.sigPresent)
            begin
              st_ff <= FD_SEARCH; // search starts on input signal
              tmr_ff <= '0;
              go_ff <= 1'b1;
              on_ff <= 1'b1;
            end
          end
          FD_SEARCH:
          begin
            on_ff <= 1'b1;
            tmr_ff <= tmr_ff + 1'b1;
            if (!evt.sigPresent)
              st_ff <= FD_WAIT;
            else if (evt.freqFound)
              st_ff <= FD_FOUND;
            else if (tmr_ff == TMR_W'(LOCK_CYCLES - 1))
            begin
              tmr_ff <= '0; // lock window missed, search again
              go_ff <= 1'b1;
            end
          end
          FD_FOUND:
          begin
            on_ff <= forceOn; // off after lock unless kept on
            if (!evt.sigPresent)
              st_ff <= FD_WAIT;
          end
          default: st_ff <= FD_WAIT;
        endcase
      end
    end
  end

  assign detectorOn = on_ff;
  assign searchStart = go_ff;
  assign locked = (st_ff == FD_FOUND);
endmodule

/* logic/tx_cdr_ctrl_regs.sv */
// transmit path control registers behind a 2-wire serial slave
`timescale 1ns/1ps
module tx_cdr_ctrl_regs
  import tx_ctrl_pkg::*;
#(
  parameter logic [6:0] DEV_ADDR = DEV_ADDR_DEF,
  parameter int LOCK_CYCLES = LOCK_CYC
) (
  input wire logic clock,
  input wire logic nrst,
  input wire logic sck,
  input wire logic sdaIn,
  output logic sdaOut,
  output logic sdaOe,
  input wire logic sigDetect,
  input wire logic freqLock,
  input wire logic [7:0] supplyMon,
  input wire logic [7:0] biasMon,
  input wire logic [7:0] pdMon,
  input wire logic [7:0] tempMon,
  output logic eqOff,
  output logic [3:0] eqLevel,
  output logic recoveryOff,
  output logic recoveryBypass,
  output logic [2:0] loopBwSelect,
  output logic fastLockOff,
  output logic detectorOn,
  output logic detectorSearch,
  output logic [1:0] detectorRatePreset,
  output logic [2:0] retimerDivider,
  output logic outInvert,
  output logic driverOff,
  output logic [7:0] modAmp
);
  import tx_ctrl_pkg::*;

  pin_evt_if evt ();

  twi_state_t st_ff;
  logic [7:0] shift_ff;
  logic [3:0] bitCnt_ff;
  logic [7:0] ptr_ff;
  logic isRead_ff;
  logic nack_ff;
  logic sdaOe_ff;
  logic wrStrobe;
  logic byteDone;
  logic [7:0] rxCtl_ff;
  logic [7:0] txCtl_ff;
  logic [7:0] eqPk_ff;
  logic [7:0] mod_ff;
  logic [7:0] rec_ff;
  logic [7:0] bw_ff;
  logic bypass_ff;
  logic fdOn;
  logic fdGo;
  logic fdLocked;
  logic [7:0] rdNow;
  logic [7:0] rdNext;

  // write decode for one register
  function automatic logic wrHit(input logic [7:0] ofs);
    wrHit = wrStrobe && (ptr_ff == ofs);
  endfunction

  // read mux, unmapped pointers return zero
  function automatic logic [7:0] regRead(input logic [7:0] a);
    case (a)
      RX_CTL_OFS: regRead = rxCtl_ff;
      TX_CTL_OFS: regRead = txCtl_ff;
      EQ_OFS: regRead = eqPk_ff;
      MOD_OFS: regRead = mod_ff;
      REC_OFS: regRead = rec_ff;
      BW_OFS: regRead = bw_ff;
      MON_SUP_OFS: regRead = supplyMon;
      MON_BIAS_OFS: regRead = biasMon;
      MON_PD_OFS: regRead = pdMon;
      MON_TEMP_OFS: regRead = tempMon;
      STAT_OFS: regRead = {5'h00, fdLocked, fdOn, bypass_ff};
      default: regRead = 8'h00;
    endcase
  endfunction

  // pin synchronisers and bus edge finding
  pin_sync u_sync (
    .clock(clock),
    .nrst(nrst),
    .sck(sck),
    .sdaIn(sdaIn),
    .sigDetect(sigDetect),
    .freqLock(freqLock),
    .evt(evt.src)
  );

  // frequency detector sequencing
  freq_det_ctrl #(
    .LOCK_CYCLES(LOCK_CYCLES)
  ) u_fd (
    .clock(clock),
    .nrst(nrst),
    .evt(evt.dst),
    .forceOn(rec_ff[REC_FD_ON]),
    .forceOff(rec_ff[REC_FD_OFF]),
    .recOff(txCtl_ff[TXC_REC_OFF]),
    .detectorOn(fdOn),
    .searchStart(fdGo),
    .locked(fdLocked)
  );

  assign byteDone = (bitCnt_ff == BYTE_BITS);
  assign wrStrobe = evt.sckFall && (st_ff == TW_WDATA) && byteDone;

  // read data for the current and the next pointer
  always_comb
  begin
    rdNow = regRead(ptr_ff);
    rdNext = regRead(ptr_ff + 8'h01);
  end

  // 2-wire slave: bits in on sck rise, sda changes on sck fall
  always_ff @(posedge clock or negedge nrst)
  begin
    if (!nrst)
    begin
      st_ff <= TW_IDLE;
      shift_ff <= 8'h00;
      bitCnt_ff <= 4'h0;
      ptr_ff <= 8'h00;
      isRead_ff <= 1'b0;
      nack_ff <= 1'b0;
      sdaOe_ff <= 1'b0;
    end
    else if (evt.stopSeen)
    begin
      st_ff <= TW_IDLE;
      sdaOe_ff <= 1'b0;
    end
    else if (evt.startSeen)
    begin
      st_ff <= TW_ADDR; // also covers repeated start
      bitCnt_ff <= 4'h0;
      sdaOe_ff <= 1'b0;
    end
    else if (evt.sckRise)
    begin
      case (st_ff)
        TW_ADDR, TW_PTR, TW_WDATA:
        begin
          shift_ff <= {shift_ff[6:0], evt.sdaLvl};
          bitCnt_ff <= bitCnt_ff + 4'h1;
        end
        TW_RDATA: bitCnt_ff <= bitCnt_ff + 4'h1;
        TW_RDATA_ACK: nack_ff <= evt.sdaLvl; // host ack is low
        default: ;
      endcase
    end
    else if (evt.sckFall)
    begin
      case (st_ff)
        TW_ADDR:
        begin
          if (byteDone)
          begin
            if (shift_ff[7:1] == DEV_ADDR)
            begin
              st_ff <= TW_ADDR_ACK;
              isRead_ff <= shift_ff[0];
              sdaOe_ff <= 1'b1; // ack
            end
            else
              st_ff <= TW_IDLE; // not ours, wait for next start
          end
        end
        TW_ADDR_ACK:
        begin
          bitCnt_ff <= 4'h0;
          if (isRead_ff)
          begin
            st_ff <= TW_RDATA;
            shift_ff <= rdNow;
            sdaOe_ff <= ~rdNow[7];
          end
          else
          begin
            st_ff <= TW_PTR;
            sdaOe_ff <= 1'b0;
          end
        end
        TW_PTR:
        begin
          if (byteDone)
          begin
            ptr_ff <= shift_ff;
            st_ff <= TW_PTR_ACK;
            sdaOe_ff <= 1'b1;
          end
        end
        TW_PTR_ACK:
        begin
          bitCnt_ff <= 4'h0;
          st_ff <= TW_WDATA;
          sdaOe_ff <= 1'b0;
        end
        TW_WDATA:
        begin
          if (byteDone)
          begin
            st_ff <= TW_WDATA_ACK;
            sdaOe_ff <= 1'b1;
          end
        end
        TW_WDATA_ACK:
        begin
          ptr_ff <= ptr_ff + 8'h01; // auto increment
          bitCnt_ff <= 4'h0;
          st_ff <= TW_WDATA;
          sdaOe_ff <= 1'b0;
        end
        TW_RDATA:
        begin
          if (byteDone)
          begin
            st_ff <= TW_RDATA_ACK;
            sdaOe_ff <= 1'b0; // release for host ack
          end
          else
          begin
            shift_ff <= {shift_ff[6:0], 1'b0};
            sdaOe_ff <= ~shift_ff[6];
          end
        end
        TW_RDATA_ACK:
        begin
          if (nack_ff)
          begin
            st_ff <= TW_IDLE;
            sdaOe_ff <= 1'b0;
          end
          else
          begin
            ptr_ff <= ptr_ff + 8'h01;
            bitCnt_ff <= 4'h0;
            st_ff <= TW_RDATA;
            shift_ff <= rdNext;
            sdaOe_ff <= ~rdNext[7];
          end
        end
        default: st_ff <= TW_IDLE;
      endcase
    end
  end

  // receive-side control, bypass companion bit
  always_ff @(posedge clock or negedge nrst)
  begin
    if (!nrst)
      rxCtl_ff <= RX_CTL_RST;
    else if (wrHit(RX_CTL_OFS))
      rxCtl_ff <= shift_ff;
  end

  // transmit path control
  always_ff @(posedge clock or negedge nrst)
  begin
    if (!nrst)
      txCtl_ff <= TX_CTL_RST;
    else if (wrHit(TX_CTL_OFS))
      txCtl_ff <= shift_ff;
  end

  // equalizer level and peaking
  always_ff @(posedge clock or negedge nrst)
  begin
    if (!nrst)
      eqPk_ff <= EQ_RST;
    else if (wrHit(EQ_OFS))
      eqPk_ff <= shift_ff;
  end

  // modulation amplitude
  always_ff @(posedge clock or negedge nrst)
  begin
    if (!nrst)
      mod_ff <= MOD_RST;
    else if (wrHit(MOD_OFS))
      mod_ff <= shift_ff;
  end

  // recovery loop configuration
  always_ff @(posedge clock or negedge nrst)
  begin
    if (!nrst)
      rec_ff <= REC_RST;
    else if (wrHit(REC_OFS))
      rec_ff <= shift_ff;
  end

  // loop bandwidth, shared by both recovery loops
  always_ff @(posedge clock or negedge nrst)
  begin
    if (!nrst)
      bw_ff <= BW_RST;
    else if (wrHit(BW_OFS))
      bw_ff <= shift_ff;
  end

  // bypass of powered loop needs both bypass bits
  always_ff @(posedge clock or negedge nrst)
  begin
    if (!nrst)
      bypass_ff <= 1'b0;
    else
      bypass_ff <= txCtl_ff[TXC_BYP] & rxCtl_ff[RXC_BYP] & ~txCtl_ff[TXC_REC_OFF];
  end

  // serial pin: open drain, only ever pulls low
  assign sdaOut = 1'b0;
  assign sdaOe = sdaOe_ff;

  // control fields out to the analog path
  assign eqOff = txCtl_ff[TXC_EQ_OFF];
  assign eqLevel = eqPk_ff[EQ_LVL_LSB +: 4];
  assign recoveryOff = txCtl_ff[TXC_REC_OFF];
  assign recoveryBypass = bypass_ff;
  assign loopBwSelect = bw_ff[BW_LSB +: 3];
  assign fastLockOff = rec_ff[REC_FL_OFF];
  assign detectorOn = fdOn;
  assign detectorSearch = fdGo;
  assign detectorRatePreset = rec_ff[REC_PRE_LSB +: 2];
  assign retimerDivider = rec_ff[REC_DIV_LSB +: 3];
  assign outInvert = txCtl_ff[TXC_INV];
  assign driverOff = txCtl_ff[TXC_DRV_OFF];
  assign modAmp = mod_ff;
endmodule

/* tb/tx_ctrl_sva.sv */
// assertion checker for the transmit-path control register block
`timescale 1ns/1ps
module tx_ctrl_sva #(
  parameter int LOCK_CYCLES = 50
) (
  input wire logic clock,
  input wire logic nrst,
  input wire logic sck,
  input wire logic sigDetect,
  input wire logic freqLock,
  input wire logic sdaOut,
  input wire logic sdaOe,
  input wire logic eqOff,
  input wire logic [3:0] eqLevel,
  input wire logic recoveryOff,
  input wire logic recoveryBypass,
  input wire logic outInvert,
  input wire logic driverOff,
  input wire logic detectorOn,
  input wire logic detectorSearch
);
  int retryCnt_ff;
  default clocking cb @(posedge clock); endclocking
  default disable iff (!nrst);
  // cycles spent searching since the last search pulse
  always_ff @(posedge clock or negedge nrst)
  begin
    if (!nrst)
      retryCnt_ff <= 0;
    else if (detectorSearch || !(detectorOn && sigDetect && !freqLock))
      retryCnt_ff <= 0;
    else
      retryCnt_ff <= retryCnt_ff + 1;
  end
  sequence s_pulse;
    detectorSearch ##1 !detectorSearch;
  endsequence
  sequence s_rec_down;
    recoveryOff ##1 !detectorOn;
  endsequence
  a_reset_idle: assert property (
    $rose(nrst) |-> !eqOff && !recoveryOff && !driverOff && !outInvert && !detectorOn
      && !sdaOe && eqLevel == 4'h0)
    else $error("outputs not idle after reset");
  a_bypass_gate: assert property (
    recoveryOff && $past(recoveryOff) |-> !recoveryBypass)
    else $error("bypass active with recovery loop off");
  a_rec_down: assert property (
    recoveryOff |-> s_rec_down)
    else $error("detector still powered with recovery loop off");
  a_search_power: assert property (
    detectorSearch |-> ##[0:1] detectorOn)
    else $error("search started with detector unpowered");
  a_search_pulse: assert property (
    detectorSearch |-> s_pulse)
    else $error("search start longer than one cycle");
  a_search_retry: assert property (
    retryCnt_ff <= LOCK_CYCLES + 8)
    else $error("search not restarted after lock timeout");
  a_drive_low: assert property (
    sdaOe |-> sdaOut == 1'b0)
    else $error("data pin driven high");
  a_ack_edge: assert property (
    $rose(sdaOe) |-> !sck)
    else $error("data pin changed while clock high");
  a_ack_bound: assert property (
    $rose(sdaOe) |-> ##[1:100] !sdaOe)
    else $error("data pin held too long");
  a_cfg_edge: assert property (
    !$stable({eqOff, eqLevel, outInvert, driverOff}) |-> !sck)
    else $error("control changed outside clock low phase");
endmodule
bind tx_cdr_ctrl_regs tx_ctrl_sva #(.LOCK_CYCLES(LOCK_CYCLES)) chk (.*);

/* tb/host_twi_model.sv */
// behavioural 2-wire host that writes and reads the device registers
`timescale 1ns/1ps
module host_twi_model (
  input wire logic clock,
  input wire logic sdaLine,
  output logic sck,
  output logic hostLow
);
  // bus idles released with clock high
  initial
  begin
    sck = 1'b1;
    hostLow = 1'b0;
  end
  task automatic tick(input int n);
    repeat (n) @(negedge clock);
  endtask
  // one bit: data set mid-low, line sampled mid-high
  task automatic bitIo(input logic b, output logic r);
    tick(2);
    hostLow = !b;
    tick(2);
    sck = 1'b1;
    tick(2);
    r = sdaLine;
    tick(2);
    sck = 1'b0;
  endtask
  // one byte msb first plus the acknowledge slot
  task automatic byteIo(input logic [7:0] d, input logic ackBit, output logic [7:0] q,
    output logic acked);
    logic r;
    for (int i = 7; i >= 0; i--)
    begin
      bitIo(d[i], r);
      q[i] = r;
    end
    bitIo(ackBit, r);
    acked = !r;
  endtask
  // start or repeated start: data falls while clock high
  task automatic startCond();
    if (!sck)
    begin
      tick(2);
      hostLow = 1'b0;
      tick(2);
      sck = 1'b1;
      tick(4);
    end
    hostLow = 1'b1;
    tick(4);
    sck = 1'b0;
  endtask
  // stop then bus free time
  task automatic stopCond();
    tick(2);
    hostLow = 1'b1;
    tick(2);
    sck = 1'b1;
    tick(4);
    hostLow = 1'b0;
    tick(33);
  endtask
  task automatic regWrite(input logic [6:0] dev, input logic [7:0] ptr, input logic [7:0] d,
    output logic ok);
    logic [7:0] q;
    logic a0, a1, a2;
    startCond();
    byteIo({dev, 1'b0}, 1'b1, q, a0);
    byteIo(ptr, 1'b1, q, a1);
    byteIo(d, 1'b1, q, a2);
    stopCond();
    ok = a0 && a1 && a2;
  endtask
  task automatic regRead(input logic [6:0] dev, input logic [7:0] ptr, output logic [7:0] d,
    output logic ok);
    logic [7:0] q;
    logic a0, a1, a2, na;
    startCond();
    byteIo({dev, 1'b0}, 1'b1, q, a0);
    byteIo(ptr, 1'b1, q, a1);
    startCond();
    byteIo({dev, 1'b1}, 1'b1, q, a2);
    byteIo(8'hFF, 1'b1, d, na); // no-ack ends the read
    stopCond();
    ok = a0 && a1 && a2;
  endtask
endmodule

/* tb/tb.sv */
// self-checking bench for the transmit-path control register block
`timescale 1ns/1ps
`define CHK(got, exp) begin compares++; if ((got) !== (exp)) begin bad_count++; \
  $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp); end end
module tb;
  import tx_ctrl_pkg::*;
  localparam logic [2:0] DIV_BY4 = 3'h2; // divide-by-four code, base of the divider sweep (reset loads code 0)
  logic clock = 1'b0;
  logic nrst = 1'b0;
  logic sigDetect = 1'b0;
  logic freqLock = 1'b0;
  logic sck, hostLow, sdaLine, sdaOut, sdaOe, ok;
  logic eqOff, recoveryOff, recoveryBypass, fastLockOff, detectorOn, detectorSearch;
  logic outInvert, driverOff;
  logic [3:0] eqLevel;
  logic [2:0] loopBwSelect, retimerDivider;
  logic [1:0] detectorRatePreset;
  logic [7:0] modAmp, recv;
  logic [7:0] mon [4] = '{8'h3C, 8'h5A, 8'h96, 8'hE1};
  logic [7:0] txv [5] = '{8'h02, 8'h10, 8'h20, 8'h40, 8'h72};
  int bad_count = 0;
  int compares = 0;
  int pulses;
  always #20 clock = !clock;
  // open-drain data line with pull-up
  assign sdaLine = !(hostLow || (sdaOe && !sdaOut));
  host_twi_model host (.clock(clock), .sdaLine(sdaLine), .sck(sck), .hostLow(hostLow));
  tx_cdr_ctrl_regs #(.LOCK_CYCLES(50)) DUT (.clock(clock), .nrst(nrst), .sck(sck),
    .sdaIn(sdaLine), .sdaOut(sdaOut), .sdaOe(sdaOe), .sigDetect(sigDetect),
    .freqLock(freqLock), .supplyMon(mon[0]), .biasMon(mon[1]), .pdMon(mon[2]),
    .tempMon(mon[3]), .eqOff(eqOff), .eqLevel(eqLevel), .recoveryOff(recoveryOff),
    .recoveryBypass(recoveryBypass), .loopBwSelect(loopBwSelect), .fastLockOff(fastLockOff),
    .detectorOn(detectorOn), .detectorSearch(detectorSearch),
    .detectorRatePreset(detectorRatePreset), .retimerDivider(retimerDivider),
    .outInvert(outInvert), .driverOff(driverOff), .modAmp(modAmp));
  task automatic end_sim();
    $display("compares=%0d bad_count=%0d", compares, bad_count);
    if (bad_count == 0 && compares > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  task automatic wr(input logic [7:0] ptr, input logic [7:0] d);
    logic a;
    host.regWrite(DEV_ADDR_DEF, ptr, d, a);
    `CHK(a, 1'b1)
  endtask
  task automatic rdChk(input logic [7:0] ptr, input logic [7:0] exp);
    logic a;
    logic [7:0] d;
    host.regRead(DEV_ADDR_DEF, ptr, d, a);
    `CHK({a, d}, {1'b1, exp})
  endtask
  // watchdog
  initial
  begin
    repeat (60000) @(posedge clock);
    bad_count++;
    end_sim();
  end
  // main sequence
  initial
  begin
    repeat (20) @(negedge clock);
    nrst = 1'b1;
    repeat (4) @(negedge clock);
    `CHK({eqOff, recoveryOff, driverOff, detectorOn}, 4'h0)
    rdChk(TX_CTL_OFS, TX_CTL_RST);
    rdChk(REC_OFS, REC_RST);
    foreach (txv[i])
    begin
      wr(TX_CTL_OFS, txv[i]);
      `CHK({driverOff, outInvert, recoveryOff, eqOff}, {txv[i][6:4], txv[i][1]})
      rdChk(TX_CTL_OFS, txv[i]);
    end
    wr(TX_CTL_OFS, 8'h08);
    `CHK(recoveryBypass, 1'b0)
    wr(RX_CTL_OFS, 8'h08);
    `CHK(recoveryBypass, 1'b1)
    rdChk(STAT_OFS, 8'h01);
    wr(TX_CTL_OFS, 8'h18);
    `CHK(recoveryBypass, 1'b0)
    for (int i = 0; i < 16; i += 5)
    begin
      wr(EQ_OFS, 8'(i));
      `CHK(eqLevel, 4'(i))
    end
    wr(BW_OFS, 8'hA0);
    `CHK(loopBwSelect, 3'h5)
    for (int p = 0; p < 4; p++)
    begin
      recv = {2'(p), 2'b00, 1'(p), DIV_BY4 + 3'(p)};
      wr(REC_OFS, recv);
      `CHK({detectorRatePreset, fastLockOff, retimerDivider}, {recv[7:6], recv[3:0]})
      rdChk(REC_OFS, recv);
    end
    wr(MOD_OFS, 8'hC3);
    `CHK(modAmp, 8'hC3)
    for (int i = 0; i < 4; i++)
      rdChk(MON_SUP_OFS + 8'(i), mon[i]);
    host.regWrite(DEV_ADDR_DEF, 8'h20, 8'h55, ok);
    rdChk(8'h20, 8'h00);
    wr(TX_CTL_OFS, 8'h00);
    wr(REC_OFS, 8'h00);
    host.regWrite(DEV_ADDR_DEF ^ 7'h01, TX_CTL_OFS, 8'h40, ok);
    `CHK({ok, driverOff}, 2'b00)
    sigDetect = 1'b1;
    pulses = 0;
    repeat (130)
    begin
      @(negedge clock);
      pulses += detectorSearch;
    end
    `CHK({detectorOn, pulses >= 2}, 2'b11)
    freqLock = 1'b1;
    repeat (10) @(negedge clock);
    `CHK(detectorOn, 1'b0)
    wr(REC_OFS, 8'h20);
    `CHK(detectorOn, 1'b1)
    rdChk(STAT_OFS, 8'h06);
    wr(REC_OFS, 8'h30);
    `CHK(detectorOn, 1'b0)
    wr(REC_OFS, 8'h20);
    `CHK(detectorOn, 1'b1)
    wr(TX_CTL_OFS, 8'h10);
    `CHK(detectorOn, 1'b0)
    wr(TX_CTL_OFS, 8'h00);
    wr(REC_OFS, 8'h10);
    `CHK(detectorOn, 1'b0)
    end_sim();
  end
endmodule
